// file: common/gpbcd_pkg.sv
`default_nettype none
package gpbcd_pkg;
   // register indices; byte address is four times the index
   localparam int unsigned IDX_ONE_DATA = 1;
   localparam int unsigned IDX_TWO_DATA = 2;
   localparam int unsigned IDX_THREE_DATA = 3;
   localparam int unsigned IDX_ONE_DIR = 5;
   localparam int unsigned IDX_TWO_DIR = 6;
   localparam int unsigned IDX_THREE_DIR = 7;
   localparam int unsigned IDX_CTRL = 8;
   localparam int unsigned ADDR_SHIFT = 2;
   // port widths
   localparam int unsigned ONE_W = 8;
   localparam int unsigned TWO_W = 7;
   localparam int unsigned THREE_W = 8;
   localparam int unsigned ANALOG_W = 4;
   localparam int unsigned CTRL_W = 7;
   // control register field positions
   localparam int unsigned CTRL_ADC_EN = 0;
   localparam int unsigned CTRL_ADC_CH_LO = 1;
   localparam int unsigned CTRL_S1_EN = 3;
   localparam int unsigned CTRL_S1_MASTER = 4;
   localparam int unsigned CTRL_S2_EN = 5;
   localparam int unsigned CTRL_S2_MASTER = 6;
   // third port pin positions
   localparam int unsigned PIN_S1_SELECT = 2;
   localparam int unsigned PIN_S2_SELECT = 5;
   // values after reset
   localparam logic [7:0] ONE_DIR_RST = 8'h00;
   localparam logic [6:0] TWO_DIR_RST = 7'h00;
   localparam logic [7:0] THREE_DIR_RST = 8'h00;
   localparam logic [6:0] CTRL_RST = 7'h00;
   // bus response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // synchroniser depth in cycles
   localparam int unsigned SYNC_STAGES = 2;
   // register selected by a bus address
   typedef enum logic [2:0] {
      SEL_NONE, SEL_ONE_DATA, SEL_TWO_DATA, SEL_THREE_DATA,
      SEL_ONE_DIR, SEL_TWO_DIR, SEL_THREE_DIR, SEL_CTRL
   } gpbcd_sel_t;
   // write channel states
   typedef enum logic {WR_IDLE, WR_RESP} gpbcd_wr_st_t;
   // read channel states
   typedef enum logic {RD_IDLE, RD_RESP} gpbcd_rd_st_t;
endpackage : gpbcd_pkg
`default_nettype wire

// file: logic/gpbcd_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bundle of pin levels
module gpbcd_sync #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   // first stage, read only by the second
   logic [W-1:0] meta_r;
   // second stage
   logic [W-1:0] sync_r;

   // both stages clear on reset
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;
endmodule : gpbcd_sync
`default_nettype wire

// file: logic/gpbcd_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
// per-pin drive and read selection for one port
module gpbcd_pin_mux #(
   parameter int unsigned W = 8
) (
   // port registers
   input wire logic [W-1:0] latch_i,
   input wire logic [W-1:0] dir_i,
   // synchronised pin level
   input wire logic [W-1:0] pin_i,
   // peripheral claim and its drive
   input wire logic [W-1:0] own_i,
   input wire logic [W-1:0] per_out_i,
   input wire logic [W-1:0] per_oe_i,
   // analog claim forces input
   input wire logic [W-1:0] analog_i,
   // pin drive and bus read value
   output logic [W-1:0] out_o,
   output logic [W-1:0] oe_o,
   output logic [W-1:0] rd_o
);
   // one identical slice per pin
   for (genvar i = 0; i < W; i++) begin : g_pin
      // analog claim wins, then peripheral, then direction bit
      assign oe_o[i] = analog_i[i] ? 1'b0 :
                       own_i[i] ? per_oe_i[i] :
                       dir_i[i];
      // driven value follows the owner
      assign out_o[i] = own_i[i] ? per_out_i[i] : latch_i[i];
      // direction bit always picks latch or pin for reads
      assign rd_o[i] = dir_i[i] ? latch_i[i] : pin_i[i];
   end
endmodule : gpbcd_pin_mux
`default_nettype wire

// file: logic/gpbcd_ports.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gpbcd_ports #(
   parameter int unsigned ADDR_W = 8
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // axi4-lite write address
   input wire logic AXI_AWVALID_I,
   output logic AXI_AWREADY_O,
   input wire logic [ADDR_W-1:0] AXI_AWADDR_I,
   // axi4-lite write data
   input wire logic AXI_WVALID_I,
   output logic AXI_WREADY_O,
   input wire logic [31:0] AXI_WDATA_I,
   input wire logic [3:0] AXI_WSTRB_I,
   // axi4-lite write response
   output logic AXI_BVALID_O,
   input wire logic AXI_BREADY_I,
   output logic [1:0] AXI_BRESP_O,
   // axi4-lite read address
   input wire logic AXI_ARVALID_I,
   output logic AXI_ARREADY_O,
   input wire logic [ADDR_W-1:0] AXI_ARADDR_I,
   // axi4-lite read data
   output logic AXI_RVALID_O,
   input wire logic AXI_RREADY_I,
   output logic [31:0] AXI_RDATA_O,
   output logic [1:0] AXI_RRESP_O,
   // first port pins
   input wire logic [7:0] ONE_PIN_I,
   output logic [7:0] ONE_PIN_O,
   output logic [7:0] ONE_PIN_OE_O,
   // pins handed to the analog converter
   output logic [3:0] ANALOG_CHANNEL_PINS_O,
   // second port pins
   input wire logic [6:0] TWO_PIN_I,
   output logic [6:0] TWO_PIN_O,
   output logic [6:0] TWO_PIN_OE_O,
   // third port pins
   input wire logic [7:0] THREE_PIN_I,
   output logic [7:0] THREE_PIN_O,
   output logic [7:0] THREE_PIN_OE_O,
   // serial interface drive per third-port pin
   input wire logic [7:0] SERIAL_OUT_I,
   input wire logic [7:0] SERIAL_OE_I,
   // serial interface view of pins and enables
   output logic [7:0] SERIAL_IN_O,
   output logic SERIAL_ENABLE_O,
   output logic SERIAL_MASTER_MODE_O,
   output logic SERIAL2_ENABLE_O,
   output logic SERIAL2_MASTER_MODE_O
);
   // whole state of the block
   typedef struct packed {
      gpbcd_pkg::gpbcd_wr_st_t wst;   // write channel state
      gpbcd_pkg::gpbcd_rd_st_t rst;   // read channel state
      logic aw_got;                    // write address held
      logic w_got;                     // write data held
      logic [ADDR_W-1:0] aw_addr;      // held write address
      logic [7:0] w_data;              // held write byte
      logic w_en;                      // held lane-0 strobe
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] one_latch;           // first port latches
      logic [7:0] one_dir;             // first port directions
      logic [6:0] two_latch;           // second port latches
      logic [6:0] two_dir;             // second port directions
      logic [7:0] three_latch;         // third port latches
      logic [7:0] three_dir;           // third port directions
      logic [6:0] ctrl;                // converter and serial control
      logic [7:0] one_out;             // registered pin drives
      logic [7:0] one_oe;
      logic [6:0] two_out;
      logic [6:0] two_oe;
      logic [7:0] three_out;
      logic [7:0] three_oe;
      logic [3:0] analog;
      logic [7:0] ser_in;
   } gpbcd_state_t;

   // current and next state
   gpbcd_state_t st_r;
   gpbcd_state_t st_nxt;

   // synchronised pin levels
   logic [7:0] one_pin;
   logic [6:0] two_pin;
   logic [7:0] three_pin;
   // analog and serial claims
   logic [7:0] one_analog;
   logic [7:0] three_own;
   // pin mux results
   logic [7:0] one_out;
   logic [7:0] one_oe;
   logic [7:0] one_rd;
   logic [6:0] two_out;
   logic [6:0] two_oe;
   logic [6:0] two_rd;
   logic [7:0] three_out;
   logic [7:0] three_oe;
   logic [7:0] three_rd;
   // decoded control fields
   logic adc_en;
   logic [1:0] adc_ch;
   logic s1_en;
   logic s1_master;
   logic s2_en;
   logic s2_master;

   // map a byte address onto a register
   function automatic gpbcd_pkg::gpbcd_sel_t decode(
      input logic [ADDR_W-1:0] addr
   );
      logic [ADDR_W-1:0] idx;
      idx = addr >> gpbcd_pkg::ADDR_SHIFT;
      if (addr[1:0] != 2'h0) begin
         decode = gpbcd_pkg::SEL_NONE;
      end else if (idx == ADDR_W'(gpbcd_pkg::IDX_ONE_DATA)) begin
         decode = gpbcd_pkg::SEL_ONE_DATA;
      end else if (idx == ADDR_W'(gpbcd_pkg::IDX_TWO_DATA)) begin
         decode = gpbcd_pkg::SEL_TWO_DATA;
      end else if (idx == ADDR_W'(gpbcd_pkg::IDX_THREE_DATA)) begin
         decode = gpbcd_pkg::SEL_THREE_DATA;
      end else if (idx == ADDR_W'(gpbcd_pkg::IDX_ONE_DIR)) begin
         decode = gpbcd_pkg::SEL_ONE_DIR;
      end else if (idx == ADDR_W'(gpbcd_pkg::IDX_TWO_DIR)) begin
         decode = gpbcd_pkg::SEL_TWO_DIR;
      end else if (idx == ADDR_W'(gpbcd_pkg::IDX_THREE_DIR)) begin
         decode = gpbcd_pkg::SEL_THREE_DIR;
      end else if (idx == ADDR_W'(gpbcd_pkg::IDX_CTRL)) begin
         decode = gpbcd_pkg::SEL_CTRL;
      end else begin
         decode = gpbcd_pkg::SEL_NONE;
      end
   endfunction : decode

   // pin level synchronisers
   gpbcd_sync #(.W(gpbcd_pkg::ONE_W)) u_sync_one (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .async_i(ONE_PIN_I),
      .sync_o(one_pin)
   );
   gpbcd_sync #(.W(gpbcd_pkg::TWO_W)) u_sync_two (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .async_i(TWO_PIN_I),
      .sync_o(two_pin)
   );
   gpbcd_sync #(.W(gpbcd_pkg::THREE_W)) u_sync_three (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .async_i(THREE_PIN_I),
      .sync_o(three_pin)
   );

   // control fields
   assign adc_en = st_r.ctrl[gpbcd_pkg::CTRL_ADC_EN];
   assign adc_ch = st_r.ctrl[gpbcd_pkg::CTRL_ADC_CH_LO +: 2];
   assign s1_en = st_r.ctrl[gpbcd_pkg::CTRL_S1_EN];
   assign s1_master = st_r.ctrl[gpbcd_pkg::CTRL_S1_MASTER];
   assign s2_en = st_r.ctrl[gpbcd_pkg::CTRL_S2_EN];
   assign s2_master = st_r.ctrl[gpbcd_pkg::CTRL_S2_MASTER];

   // one-hot analog claim on the low four pins only
   assign one_analog = adc_en ? (8'h01 << adc_ch) : 8'h00;

   // serial claims: pins 0-3 first interface, 4-7 second
   always_comb begin
      three_own = {{4{s2_en}}, {4{s1_en}}};
      // select pins are released in master mode
      three_own[gpbcd_pkg::PIN_S1_SELECT] = s1_en && !s1_master;
      three_own[gpbcd_pkg::PIN_S2_SELECT] = s2_en && !s2_master;
   end

   // first port: analog claim, no serial
   gpbcd_pin_mux #(.W(gpbcd_pkg::ONE_W)) u_mux_one (
      .latch_i(st_r.one_latch),
      .dir_i(st_r.one_dir),
      .pin_i(one_pin),
      .own_i(8'h00),
      .per_out_i(8'h00),
      .per_oe_i(8'h00),
      .analog_i(one_analog),
      .out_o(one_out),
      .oe_o(one_oe),
      .rd_o(one_rd)
   );
   // second port: plain pins
   gpbcd_pin_mux #(.W(gpbcd_pkg::TWO_W)) u_mux_two (
      .latch_i(st_r.two_latch),
      .dir_i(st_r.two_dir),
      .pin_i(two_pin),
      .own_i(7'h00),
      .per_out_i(7'h00),
      .per_oe_i(7'h00),
      .analog_i(7'h00),
      .out_o(two_out),
      .oe_o(two_oe),
      .rd_o(two_rd)
   );
   // third port: serial claims
   gpbcd_pin_mux #(.W(gpbcd_pkg::THREE_W)) u_mux_three (
      .latch_i(st_r.three_latch),
      .dir_i(st_r.three_dir),
      .pin_i(three_pin),
      .own_i(three_own),
      .per_out_i(SERIAL_OUT_I),
      .per_oe_i(SERIAL_OE_I),
      .analog_i(8'h00),
      .out_o(three_out),
      .oe_o(three_oe),
      .rd_o(three_rd)
   );

   // next-state logic: bus slave, registers, pin drives
   always_comb begin
      logic aw_hs;
      logic w_hs;
      logic ar_hs;
      logic [ADDR_W-1:0] waddr;
      logic [7:0] wbyte;
      logic wlane;
      gpbcd_pkg::gpbcd_sel_t wsel;
      gpbcd_pkg::gpbcd_sel_t rsel;
      aw_hs = AXI_AWVALID_I && st_r.awready;
      w_hs = AXI_WVALID_I && st_r.wready;
      ar_hs = AXI_ARVALID_I && st_r.arready;
      waddr = aw_hs ? AXI_AWADDR_I : st_r.aw_addr;
      wbyte = w_hs ? AXI_WDATA_I[7:0] : st_r.w_data;
      wlane = w_hs ? AXI_WSTRB_I[0] : st_r.w_en;
      wsel = decode(waddr);
      rsel = decode(AXI_ARADDR_I);
      st_nxt = st_r;
      // pin drives registered every cycle
      st_nxt.one_out = one_out;
      st_nxt.one_oe = one_oe;
      st_nxt.two_out = two_out;
      st_nxt.two_oe = two_oe;
      st_nxt.three_out = three_out;
      st_nxt.three_oe = three_oe;
      st_nxt.analog = one_analog[3:0];
      st_nxt.ser_in = three_pin;
      // write channel
      case (st_r.wst)
         gpbcd_pkg::WR_IDLE: begin
            // capture address and data in either order
            if (aw_hs) begin
               st_nxt.aw_got = 1'b1;
               st_nxt.aw_addr = AXI_AWADDR_I;
               st_nxt.awready = 1'b0;
            end
            if (w_hs) begin
               st_nxt.w_got = 1'b1;
               st_nxt.w_data = AXI_WDATA_I[7:0];
               st_nxt.w_en = AXI_WSTRB_I[0];
               st_nxt.wready = 1'b0;
            end
            // both present: perform write and answer
            if ((aw_hs || st_r.aw_got) && (w_hs || st_r.w_got)) begin
               st_nxt.aw_got = 1'b0;
               st_nxt.w_got = 1'b0;
               st_nxt.awready = 1'b0;
               st_nxt.wready = 1'b0;
               st_nxt.bvalid = 1'b1;
               st_nxt.bresp = gpbcd_pkg::RESP_OKAY;
               st_nxt.wst = gpbcd_pkg::WR_RESP;
               // latches load whatever the direction bits
               if (wsel == gpbcd_pkg::SEL_NONE) begin
                  st_nxt.bresp = gpbcd_pkg::RESP_SLVERR;
               end else if (!wlane) begin
                  st_nxt.bresp = gpbcd_pkg::RESP_OKAY;
               end else if (wsel == gpbcd_pkg::SEL_ONE_DATA) begin
                  st_nxt.one_latch = wbyte;
               end else if (wsel == gpbcd_pkg::SEL_TWO_DATA) begin
                  st_nxt.two_latch = wbyte[6:0];
               end else if (wsel == gpbcd_pkg::SEL_THREE_DATA) begin
                  st_nxt.three_latch = wbyte;
               end else if (wsel == gpbcd_pkg::SEL_ONE_DIR) begin
                  st_nxt.one_dir = wbyte;
               end else if (wsel == gpbcd_pkg::SEL_TWO_DIR) begin
                  st_nxt.two_dir = wbyte[6:0];
               end else if (wsel == gpbcd_pkg::SEL_THREE_DIR) begin
                  st_nxt.three_dir = wbyte;
               end else begin
                  st_nxt.ctrl = wbyte[6:0];
               end
            end
         end
         gpbcd_pkg::WR_RESP: begin
            // hold response until taken
            if (AXI_BREADY_I) begin
               st_nxt.bvalid = 1'b0;
               st_nxt.awready = 1'b1;
               st_nxt.wready = 1'b1;
               st_nxt.wst = gpbcd_pkg::WR_IDLE;
            end
         end
         default: begin
            st_nxt.wst = gpbcd_pkg::WR_IDLE;
         end
      endcase
      // read channel
      case (st_r.rst)
         gpbcd_pkg::RD_IDLE: begin
            if (ar_hs) begin
               st_nxt.arready = 1'b0;
               st_nxt.rvalid = 1'b1;
               st_nxt.rresp = gpbcd_pkg::RESP_OKAY;
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rst = gpbcd_pkg::RD_RESP;
               // data reads pick latch or pin per direction bit
               if (rsel == gpbcd_pkg::SEL_ONE_DATA) begin
                  st_nxt.rdata[7:0] = one_rd;
               end else if (rsel == gpbcd_pkg::SEL_TWO_DATA) begin
                  st_nxt.rdata[6:0] = two_rd;
               end else if (rsel == gpbcd_pkg::SEL_THREE_DATA) begin
                  st_nxt.rdata[7:0] = three_rd;
               end else if (rsel == gpbcd_pkg::SEL_ONE_DIR) begin
                  st_nxt.rdata[7:0] = st_r.one_dir;
               end else if (rsel == gpbcd_pkg::SEL_TWO_DIR) begin
                  st_nxt.rdata[6:0] = st_r.two_dir;
               end else if (rsel == gpbcd_pkg::SEL_THREE_DIR) begin
                  st_nxt.rdata[7:0] = st_r.three_dir;
               end else if (rsel == gpbcd_pkg::SEL_CTRL) begin
                  st_nxt.rdata[6:0] = st_r.ctrl;
               end else begin
                  st_nxt.rresp = gpbcd_pkg::RESP_SLVERR;
               end
            end
         end
         gpbcd_pkg::RD_RESP: begin
            // hold data until taken
            if (AXI_RREADY_I) begin
               st_nxt.rvalid = 1'b0;
               st_nxt.arready = 1'b1;
               st_nxt.rst = gpbcd_pkg::RD_IDLE;
            end
         end
         default: begin
            st_nxt.rst = gpbcd_pkg::RD_IDLE;
         end
      endcase
   end

   // state register; port latches keep their value through reset
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         st_r.wst <= gpbcd_pkg::WR_IDLE;
         st_r.rst <= gpbcd_pkg::RD_IDLE;
         st_r.aw_got <= 1'b0;
         st_r.w_got <= 1'b0;
         st_r.aw_addr <= '0;
         st_r.w_data <= 8'h00;
         st_r.w_en <= 1'b0;
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.bvalid <= 1'b0;
         st_r.bresp <= gpbcd_pkg::RESP_OKAY;
         st_r.arready <= 1'b1;
         st_r.rvalid <= 1'b0;
         st_r.rresp <= gpbcd_pkg::RESP_OKAY;
         st_r.rdata <= 32'h0000_0000;
         st_r.one_dir <= gpbcd_pkg::ONE_DIR_RST;
         st_r.two_dir <= gpbcd_pkg::TWO_DIR_RST;
         st_r.three_dir <= gpbcd_pkg::THREE_DIR_RST;
         st_r.ctrl <= gpbcd_pkg::CTRL_RST;
         st_r.one_out <= 8'h00;
         st_r.one_oe <= 8'h00;
         st_r.two_out <= 7'h00;
         st_r.two_oe <= 7'h00;
         st_r.three_out <= 8'h00;
         st_r.three_oe <= 8'h00;
         st_r.analog <= 4'h0;
         st_r.ser_in <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign AXI_AWREADY_O = st_r.awready;
   assign AXI_WREADY_O = st_r.wready;
   assign AXI_BVALID_O = st_r.bvalid;
   assign AXI_BRESP_O = st_r.bresp;
   assign AXI_ARREADY_O = st_r.arready;
   assign AXI_RVALID_O = st_r.rvalid;
   assign AXI_RDATA_O = st_r.rdata;
   assign AXI_RRESP_O = st_r.rresp;
   assign ONE_PIN_O = st_r.one_out;
   assign ONE_PIN_OE_O = st_r.one_oe;
   assign ANALOG_CHANNEL_PINS_O = st_r.analog;
   assign TWO_PIN_O = st_r.two_out;
   assign TWO_PIN_OE_O = st_r.two_oe;
   assign THREE_PIN_O = st_r.three_out;
   assign THREE_PIN_OE_O = st_r.three_oe;
   assign SERIAL_IN_O = st_r.ser_in;
   assign SERIAL_ENABLE_O = st_r.ctrl[gpbcd_pkg::CTRL_S1_EN];
   assign SERIAL_MASTER_MODE_O = st_r.ctrl[gpbcd_pkg::CTRL_S1_MASTER];
   assign SERIAL2_ENABLE_O = st_r.ctrl[gpbcd_pkg::CTRL_S2_EN];
   assign SERIAL2_MASTER_MODE_O = st_r.ctrl[gpbcd_pkg::CTRL_S2_MASTER];
endmodule : gpbcd_ports
`default_nettype wire

// file: testbench/gpbcd_ports_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port checks
module gpbcd_ports_assertions (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // bus handshakes
   input wire logic AXI_AWVALID_I,
   input wire logic AXI_AWREADY_O,
   input wire logic AXI_WVALID_I,
   input wire logic AXI_WREADY_O,
   input wire logic AXI_BVALID_O,
   input wire logic AXI_BREADY_I,
   input wire logic [1:0] AXI_BRESP_O,
   input wire logic AXI_ARVALID_I,
   input wire logic AXI_ARREADY_O,
   input wire logic AXI_RVALID_O,
   input wire logic AXI_RREADY_I,
   input wire logic [31:0] AXI_RDATA_O,
   // pins
   input wire logic [7:0] ONE_PIN_OE_O,
   input wire logic [3:0] ANALOG_CHANNEL_PINS_O,
   input wire logic [7:0] THREE_PIN_OE_O,
   input wire logic [7:0] SERIAL_OE_I,
   input wire logic SERIAL_ENABLE_O,
   input wire logic SERIAL_MASTER_MODE_O,
   input wire logic SERIAL2_ENABLE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   // handshakes
   sequence s_aw; AXI_AWVALID_I && AXI_AWREADY_O; endsequence
   sequence s_wr; s_aw ##0 (AXI_WVALID_I && AXI_WREADY_O); endsequence
   // enable held
   sequence s_en1; $past(SERIAL_ENABLE_O) && SERIAL_ENABLE_O; endsequence
   sequence s_en2; $past(SERIAL2_ENABLE_O) && SERIAL2_ENABLE_O; endsequence
   AST_WR_ANSWER: assert property (s_wr |=> AXI_BVALID_O)
      else $error("b late");
   AST_AW_BLOCKED: assert property (s_aw |=> !AXI_AWREADY_O)
      else $error("aw open");
   AST_B_HOLD: assert property (AXI_BVALID_O && !AXI_BREADY_I
      |=> AXI_BVALID_O && $stable(AXI_BRESP_O)) else $error("b dropped");
   AST_RD_ANSWER: assert property (AXI_ARVALID_I && AXI_ARREADY_O
      |=> AXI_RVALID_O && !AXI_ARREADY_O) else $error("r late");
   AST_R_HOLD: assert property (AXI_RVALID_O && !AXI_RREADY_I
      |=> AXI_RVALID_O && $stable(AXI_RDATA_O)) else $error("r dropped");
   AST_R_UPPER: assert property (AXI_RVALID_O
      |-> AXI_RDATA_O[31:8] == '0) else $error("upper set");
   AST_ANALOG_INPUT: assert property (
      (ONE_PIN_OE_O[3:0] & ANALOG_CHANNEL_PINS_O) == 4'h0)
      else $error("analog oe");
   AST_ANALOG_ONE: assert property ($onehot0(ANALOG_CHANNEL_PINS_O))
      else $error("two analog pins");
   AST_S1_DRIVE: assert property (s_en1 |->
      THREE_PIN_OE_O[1:0] == $past(SERIAL_OE_I[1:0])
      && THREE_PIN_OE_O[3] == $past(SERIAL_OE_I[3]))
      else $error("s1 oe");
   AST_S1_SELECT: assert property (s_en1 ##0 !SERIAL_MASTER_MODE_O
      && !$past(SERIAL_MASTER_MODE_O)
      |-> THREE_PIN_OE_O[2] == $past(SERIAL_OE_I[2]))
      else $error("ss1 oe");
   AST_S2_DRIVE: assert property (s_en2 |->
      THREE_PIN_OE_O[7:6] == $past(SERIAL_OE_I[7:6])
      && THREE_PIN_OE_O[4] == $past(SERIAL_OE_I[4]))
      else $error("s2 oe");
endmodule : gpbcd_ports_assertions
bind gpbcd_ports gpbcd_ports_assertions u_chk (.*);
`default_nettype wire

// file: testbench/gpbcd_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side pad
module gpbcd_pad_model #(
   parameter int unsigned W = 8
) (
   // device drive
   input wire logic [W-1:0] out_i,
   input wire logic [W-1:0] oe_i,
   // outside level
   input wire logic [W-1:0] ext_i,
   // pin level
   output logic [W-1:0] pin_o
);
   // resolve
   assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : gpbcd_pad_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // port nets
   logic CLK_I, RESET_I, AXI_AWVALID_I, AXI_WVALID_I, AXI_BREADY_I;
   logic AXI_ARVALID_I, AXI_RREADY_I, AXI_AWREADY_O, AXI_WREADY_O;
   logic AXI_BVALID_O, AXI_ARREADY_O, AXI_RVALID_O;
   logic [7:0] AXI_AWADDR_I, AXI_ARADDR_I, SERIAL_OUT_I, SERIAL_OE_I;
   logic [31:0] AXI_WDATA_I, AXI_RDATA_O, rnd;
   logic [3:0] AXI_WSTRB_I, ANALOG_CHANNEL_PINS_O;
   logic [1:0] AXI_BRESP_O, AXI_RRESP_O, resp;
   logic [7:0] ONE_PIN_I, ONE_PIN_O, ONE_PIN_OE_O, SERIAL_IN_O;
   logic [7:0] THREE_PIN_I, THREE_PIN_O, THREE_PIN_OE_O;
   logic [6:0] TWO_PIN_I, TWO_PIN_O, TWO_PIN_OE_O, ext2, l2, d2;
   logic SERIAL_ENABLE_O, SERIAL_MASTER_MODE_O;
   logic SERIAL2_ENABLE_O, SERIAL2_MASTER_MODE_O;
   // bench copies
   logic [7:0] ext1, ext3, l1, l3, d1, d3, got, eoe, eout, soe, sout;
   int error_cnt = 0, total_checks = 0, seed = 23, i;
   gpbcd_ports DUT (.*);
   gpbcd_pad_model #(.W(8)) u_p1 (.out_i(ONE_PIN_O), .oe_i(ONE_PIN_OE_O),
      .ext_i(ext1), .pin_o(ONE_PIN_I));
   gpbcd_pad_model #(.W(7)) u_p2 (.out_i(TWO_PIN_O), .oe_i(TWO_PIN_OE_O),
      .ext_i(ext2), .pin_o(TWO_PIN_I));
   gpbcd_pad_model #(.W(8)) u_p3 (.out_i(THREE_PIN_O),
      .oe_i(THREE_PIN_OE_O), .ext_i(ext3), .pin_o(THREE_PIN_I));
   // 40 MHz clock
   initial begin
      CLK_I = 1'h0;
      forever #12.5 CLK_I = ~CLK_I;
   end
   // expected read
   function automatic logic [7:0] mixr(input logic [7:0] d, l, e);
      return (d & l) | (~d & e);
   endfunction : mixr
   // serial-owned pins
   function automatic logic [7:0] own(input logic [3:0] k);
      return {k[2], k[2], k[2] & !k[3], k[2], k[0], k[0] & !k[1], k[0], k[0]};
   endfunction : own
   // compare and count
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   // one write
   task automatic wr(input logic [7:0] a, d);
      int n;
      @(posedge CLK_I);
      AXI_AWVALID_I <= 1'h1;
      AXI_WVALID_I <= 1'h1;
      AXI_AWADDR_I <= a;
      AXI_WDATA_I <= 32'(d);
      AXI_BREADY_I <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge CLK_I);
         if (AXI_AWVALID_I && AXI_AWREADY_O) AXI_AWVALID_I <= 1'h0;
         if (AXI_WVALID_I && AXI_WREADY_O) AXI_WVALID_I <= 1'h0;
         if (AXI_BVALID_O) break;
      end
      resp = AXI_BRESP_O;
      AXI_BREADY_I <= 1'h0;
      if (n == 50) begin error_cnt++; report_and_stop(); end
   endtask : wr
   // one read
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge CLK_I);
      AXI_ARVALID_I <= 1'h1;
      AXI_ARADDR_I <= a;
      AXI_RREADY_I <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge CLK_I);
         if (AXI_ARVALID_I && AXI_ARREADY_O) AXI_ARVALID_I <= 1'h0;
         if (AXI_RVALID_O) break;
      end
      {resp, got} = {AXI_RRESP_O, AXI_RDATA_O[7:0]};
      AXI_RREADY_I <= 1'h0;
      if (n == 50) begin error_cnt++; report_and_stop(); end
   endtask : rd
   // main sequence
   initial begin
      {AXI_AWVALID_I, AXI_WVALID_I, AXI_BREADY_I} = 3'h0;
      {AXI_ARVALID_I, AXI_RREADY_I, AXI_AWADDR_I, AXI_ARADDR_I} = '0;
      {AXI_WDATA_I, AXI_WSTRB_I} = {32'h0000_0000, 4'hF};
      {SERIAL_OUT_I, SERIAL_OE_I, ext1, ext2, ext3} = '0;
      RESET_I = 1'h1;
      repeat (10) @(posedge CLK_I);
      RESET_I <= 1'h0;
      for (i = 0; i < 4; i++) begin
         rd(8'h14 + 8'(4 * i));
         chk("dir_rst", got, 32'h0000_0000);
      end
      $display("reset done");
      for (i = 0; i < 12; i++) begin
         rnd = $random(seed);
         {l1, l3, d1, d3} = rnd;
         rnd = $random(seed);
         {ext1, ext3} <= rnd[15:0];
         {l2, d2} = rnd[29:16];
         ext2 <= ~rnd[29:23];
         if (i < 2) {d1, d2, d3} = {23{i[0]}};
         wr(8'h04, l1);
         wr(8'h08, {1'h1, l2});
         wr(8'h0C, l3);
         wr(8'h14, d1);
         wr(8'h18, {1'h1, d2});
         wr(8'h1C, d3);
         repeat (4) @(posedge CLK_I);
         chk("one_oe", ONE_PIN_OE_O, d1);
         chk("one_out", ONE_PIN_O & d1, l1 & d1);
         chk("two_oe", TWO_PIN_OE_O, d2);
         chk("two_out", TWO_PIN_O & d2, l2 & d2);
         chk("oe3", THREE_PIN_OE_O, d3);
         rd(8'h04);
         chk("rd1", got, mixr(d1, l1, ext1));
         rd(8'h08);
         chk("rd2", got, mixr(d2, l2, ext2));
         rd(8'h18);
         chk("two_dir", got, d2);
         rd(8'h0C);
         chk("rd3", got, mixr(d3, l3, ext3));
         wr(8'h04, ~l1);
         rd(8'h04);
         chk("rewrite", got, mixr(d1, ~l1, ext1));
      end
      $display("ports done");
      wr(8'h14, 8'hFF);
      for (i = 0; i < 5; i++) begin
         wr(8'h20, (i < 4) ? {5'h00, i[1:0], 1'h1} : 8'h06);
         repeat (4) @(posedge CLK_I);
         chk("analog_sel", ANALOG_CHANNEL_PINS_O, (4'h1 << i) & 4'hF);
         chk("analog_oe", ONE_PIN_OE_O, 8'hFF ^ (8'(i < 4) << i));
      end
      $display("analog done");
      for (i = 0; i < 16; i++) begin
         rnd = $random(seed);
         {sout, soe, d3} = rnd[23:0];
         {SERIAL_OUT_I, SERIAL_OE_I, ext3} <= {sout, soe, rnd[31:24]};
         wr(8'h1C, d3);
         wr(8'h20, {1'h0, i[3:0], 3'h0});
         repeat (4) @(posedge CLK_I);
         eoe = mixr(own(i[3:0]), soe, d3);
         eout = mixr(own(i[3:0]), sout, l3);
         chk("ser_oe", THREE_PIN_OE_O, eoe);
         chk("ser_in", SERIAL_IN_O, mixr(eoe, eout, ext3));
         chk("ser_ctl", {SERIAL2_MASTER_MODE_O, SERIAL2_ENABLE_O,
            SERIAL_MASTER_MODE_O, SERIAL_ENABLE_O}, i[3:0]);
         rd(8'h0C);
         chk("ser_rd", got, mixr(d3, l3, mixr(eoe, eout, ext3)));
      end
      $display("serial done");
      wr(8'h24, 8'h5A);
      chk("bad_wr", resp, 2'h2);
      rd(8'h10);
      chk("bad_rd", {resp, got}, 10'h200);
      $display("unmapped done");
      wr(8'h20, 8'h00);
      wr(8'h04, 8'hA5);
      wr(8'h08, 8'h3C);
      wr(8'h0C, 8'h96);
      RESET_I <= 1'h1;
      repeat (3) @(posedge CLK_I);
      RESET_I <= 1'h0;
      chk("oe_reset", {ONE_PIN_OE_O, THREE_PIN_OE_O}, 16'h0000);
      for (i = 0; i < 3; i++) wr(8'h14 + 8'(4 * i), 8'hFF);
      rd(8'h04);
      chk("kept1", got, 8'hA5);
      rd(8'h08);
      chk("kept2", got, 8'h3C);
      rd(8'h0C);
      chk("kept3", got, 8'h96);
      $display("keep done");
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
